// ---- hw/swd_pkg.sv ----
// Package of the slow-clock watchdog block: register map, field layout,
// reset values, timing constants and the state record of the top module.
// Assumes an 8-bit register port with 16-bit byte addresses.
package swd_pkg;

    // Clock rates and the 32 kHz enable divider
    localparam int unsigned CLK_HZ        = 125000000;
    localparam int unsigned SLOW_CLK_HZ   = 32768;
    localparam int unsigned SLOW_DIV_CYC  = CLK_HZ / SLOW_CLK_HZ;
    localparam int unsigned DIV_W         = 12;

    // Register offsets (byte addresses)
    localparam logic [15:0] ADDR_SLOW_CFG = 16'hA0D8;
    localparam logic [15:0] ADDR_SLOW_TOL = 16'hA0D9;
    localparam logic [15:0] ADDR_SLOW_TOH = 16'hA0DA;
    localparam logic [15:0] ADDR_BACK_CFG = 16'hA0DB;
    localparam logic [15:0] ADDR_BACK_TOL = 16'hA0DC;
    localparam logic [15:0] ADDR_BACK_TOH = 16'hA0DD;
    localparam logic [15:0] ADDR_TA       = 16'hA0E0;
    localparam logic [15:0] ADDR_MAIN_CFG = 16'hA0E1;
    localparam logic [15:0] ADDR_IRQ_STS  = 16'hA0E2;
    localparam logic [15:0] ADDR_IRQ_MSK  = 16'hA0E3;

    // Configuration field positions
    localparam int unsigned CFG_CLR_BIT   = 7;
    localparam int unsigned CFG_REN_BIT   = 6;
    localparam int unsigned CFG_RF_BIT    = 5;
    localparam int unsigned CFG_IEN_BIT   = 4;
    localparam int unsigned CFG_CS_LSB    = 1;
    localparam int unsigned CFG_IF_BIT    = 0;
    localparam int unsigned BCFG_RF_BIT   = 0;
    localparam int unsigned MCFG_SEL_LSB  = 0;
    localparam int unsigned MCFG_REN_BIT  = 3;
    localparam int unsigned MCFG_RWT_BIT  = 7;

    // Reset values
    localparam logic [7:0]  SLOW_CFG_RST  = 8'hA7;
    localparam logic [15:0] SLOW_TO_RST   = 16'h0FFF;
    localparam logic [7:0]  BACK_CFG_RST  = 8'hD1;
    localparam logic [15:0] BACK_TO_RST   = 16'h00FF;
    localparam logic [2:0]  MAIN_SEL_RST  = 3'h3;
    localparam logic        MAIN_REN_RST  = 1'b1;

    // Timed access unlock sequence and window
    localparam logic [7:0]  TA_KEY1       = 8'hAA;
    localparam logic [7:0]  TA_KEY2       = 8'h55;
    localparam logic [2:0]  TA_WINDOW_CYC = 3'h4;

    // Interrupt status bit positions
    localparam int unsigned STS_MAIN      = 0;
    localparam int unsigned STS_SLOW      = 1;
    localparam int unsigned STS_BACK      = 2;
    localparam int unsigned STS_W         = 3;

    // Main watchdog counter width
    localparam int unsigned MAIN_W        = 27;

    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic [14:0]       pre;
        logic              ta_armed;
        logic [2:0]        ta_open;
        logic [MAIN_W-1:0] main_cnt;
        logic [2:0]        main_sel;
        logic              main_ren;
        logic              slow_ren;
        logic              slow_rf;
        logic              slow_ien;
        logic              slow_if;
        logic [2:0]        scale;
        logic [15:0]       slow_to;
        logic              back_rf;
        logic [STS_W-1:0]  sts;
        logic [STS_W-1:0]  msk;
        logic [7:0]        rdata;
        logic              rst_req;
    } swd_top_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic        match;
    } swd_dog_s;

endpackage

// ---- hw/swd_dog_if.sv ----
// Interface between the top module and one 16-bit slow-clock watchdog.
// Assumes both ends sit on ref_clk.
`timescale 1ns/1ps
interface swd_dog_if;
    logic        tick;
    logic        clear;
    logic [15:0] timeout;
    logic [15:0] count;
    logic        match;

    modport ctrl (output tick, output clear, output timeout, input count, input match);
    modport dog  (input tick, input clear, input timeout, output count, output match);
endinterface

// ---- hw/swd_dog.sv ----
// One 16-bit watchdog counter advanced by a prescaled slow tick.
// Assumes tick and clear are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
module swd_dog
    import swd_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    swd_dog_if.dog    bus
);

    swd_dog_s s_q;
    swd_dog_s s_d;

    // Count on each tick, restart after a match; clear has priority
    always_comb begin
        s_d       = s_q;
        s_d.match = 1'b0;
        if (bus.clear) begin
            s_d.cnt = 16'h0000;
        end else if (bus.tick) begin
            if (s_q.cnt == bus.timeout) begin
                s_d.match = 1'b1;
                s_d.cnt   = 16'h0000;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.count = s_q.cnt;
    assign bus.match = s_q.match;

    // Match only on a tick seen at the time-out value
    a_dog_match_cause: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(bus.match) |-> $past(bus.tick) && $past(s_q.cnt) == $past(bus.timeout))
        else $error("dog match without reaching time-out");

endmodule

// ---- hw/swd_top.sv ----
// Slow-clock watchdog block: main CPU-clock watchdog time-out control,
// slow watchdog and backup watchdog, timed-access lock and register port.
// Assumes all inputs are synchronous to ref_clk and the register master
// keeps strobes one cycle long and never both at once.
//
// Operation
// - Main select 000/001/010/011 expires after 131072/1048576/8388608/67108864 clocks.
// - Slow watchdog is a 16-bit counter on the 32 kHz slow clock.
// - Writing one to slow clear zeroes the count; bit reads back zero.
// - Slow reset flag set on its reset; held until software writes zero.
// - Slow irq flag set per event only while slow reset enable is off; request only with enable; zero-write clears.
// - Scale 000-011 divides by 2^8, 100-111 by 2^12 to 2^15.
// - Slow count matched to 16-bit time-out; reads return live count.
// - Slow and backup config and slow time-out writes need timed-access unlock; main select and reset enable writes do not.
// - Backup watchdog cannot be disabled in normal mode.
// - Backup watchdog uses the same tick scale codes as slow watchdog.
// - Backup match always resets; its time-out reads return live count.
// - Backup out of reset: 8 ms tick, about 2^8 ticks.
// - Main watchdog counts on CPU clock, halts in idle and stop.
// - Main restart write clears count only after timed-access unlock.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module swd_top
    import swd_pkg::*;
#(
    parameter logic [MAIN_W-1:0] MAIN_TO0 = 27'd131072,
    parameter logic [MAIN_W-1:0] MAIN_TO1 = 27'd1048576,
    parameter logic [MAIN_W-1:0] MAIN_TO2 = 27'd8388608,
    parameter logic [MAIN_W-1:0] MAIN_TO3 = 27'd67108864,
    parameter int unsigned       SLOW_DIV = SLOW_DIV_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        cpu_clk_en,
    input  wire logic        cpu_idle,
    input  wire logic        cpu_stop,
    output logic             slow_dog_irq,
    output logic             slow_dog_wakeup,
    output logic             wdog_reset_req,
    output logic             irq
);

    swd_top_s s_q;
    swd_top_s s_d;

    swd_dog_if slow_if ();
    swd_dog_if back_if ();

    logic              slow_clock_32k;
    logic              dog_tick;
    logic              ta_ok;
    logic              wr_slow_cfg;
    logic              wr_back_cfg;
    logic              main_expire;
    logic [MAIN_W-1:0] main_limit;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Prescaler mask for a scale code
    function automatic logic [14:0] scale_mask(input logic [2:0] code);
        unique case (code)
            3'h4:    scale_mask = 15'h0FFF;
            3'h5:    scale_mask = 15'h1FFF;
            3'h6:    scale_mask = 15'h3FFF;
            3'h7:    scale_mask = 15'h7FFF;
            default: scale_mask = 15'h00FF;
        endcase
    endfunction

    // Expiry count for a main select code; upper codes take the longest
    function automatic logic [MAIN_W-1:0] main_to(input logic [2:0] code);
        unique case (code)
            3'h0:    main_to = MAIN_TO0;
            3'h1:    main_to = MAIN_TO1;
            3'h2:    main_to = MAIN_TO2;
            default: main_to = MAIN_TO3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode

    // Slow clock enable and shared tick; one prescaler keeps both dogs in step
    assign slow_clock_32k = (s_q.div == DIV_W'(SLOW_DIV - 1));
    assign dog_tick       = slow_clock_32k && ((s_q.pre & scale_mask(s_q.scale)) == scale_mask(s_q.scale));
    assign ta_ok          = (s_q.ta_open != 3'h0);
    assign wr_slow_cfg    = reg_wr && ta_ok && (reg_addr == ADDR_SLOW_CFG);
    assign wr_back_cfg    = reg_wr && ta_ok && (reg_addr == ADDR_BACK_CFG);
    assign main_limit     = main_to(s_q.main_sel);
    assign main_expire    = cpu_clk_en && !cpu_idle && !cpu_stop && (s_q.main_cnt == main_limit - 1'b1);

    // Dog connections; the backup dog has no enable at all
    assign slow_if.tick    = dog_tick;
    assign slow_if.clear   = wr_slow_cfg && reg_wdata[CFG_CLR_BIT];
    assign slow_if.timeout = s_q.slow_to;
    assign back_if.tick    = dog_tick;
    assign back_if.clear   = wr_back_cfg && reg_wdata[CFG_CLR_BIT];
    assign back_if.timeout = BACK_TO_RST;

    swd_dog u_slow (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bus     (slow_if.dog)
    );

    swd_dog u_back (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bus     (back_if.dog)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d         = s_q;
        s_d.rst_req = 1'b0;
        s_d.rdata   = 8'h00;

        // Slow clock divider and tick prescaler
        s_d.div = slow_clock_32k ? '0 : s_q.div + 1'b1;
        if (slow_clock_32k) begin
            s_d.pre = s_q.pre + 15'h0001;
        end

        // Timed access: key pair opens a short window, one protected write closes it
        if (ta_ok) begin
            s_d.ta_open = s_q.ta_open - 3'h1;
        end
        if (reg_wr && reg_addr == ADDR_TA) begin
            s_d.ta_armed = (reg_wdata == TA_KEY1);
            if (s_q.ta_armed && reg_wdata == TA_KEY2) begin
                s_d.ta_open = TA_WINDOW_CYC;
            end
        end else if (reg_wr && ta_ok && (reg_addr inside {ADDR_SLOW_CFG, ADDR_SLOW_TOL, ADDR_SLOW_TOH,
                                                          ADDR_BACK_CFG, ADDR_MAIN_CFG})) begin
            s_d.ta_open  = 3'h0;
            s_d.ta_armed = 1'b0;
        end else if (reg_wr) begin
            s_d.ta_armed = 1'b0;
        end

        // Main watchdog counts only while the CPU clock runs
        if (cpu_clk_en && !cpu_idle && !cpu_stop) begin
            s_d.main_cnt = main_expire ? '0 : s_q.main_cnt + 1'b1;
        end
        if (reg_wr && reg_addr == ADDR_MAIN_CFG) begin
            s_d.main_sel = reg_wdata[MCFG_SEL_LSB +: 3];
            s_d.main_ren = reg_wdata[MCFG_REN_BIT];
            if (ta_ok && reg_wdata[MCFG_RWT_BIT]) begin
                s_d.main_cnt = '0;
            end
        end

        // Software register writes; config flags only clear by a written zero, status bits by a written one
        if (wr_slow_cfg) begin
            s_d.slow_ren = reg_wdata[CFG_REN_BIT];
            s_d.slow_rf  = s_q.slow_rf & reg_wdata[CFG_RF_BIT];
            s_d.slow_ien = reg_wdata[CFG_IEN_BIT];
            s_d.scale    = reg_wdata[CFG_CS_LSB +: 3];
            s_d.slow_if  = s_q.slow_if & reg_wdata[CFG_IF_BIT];
        end
        if (reg_wr && ta_ok && reg_addr == ADDR_SLOW_TOL) begin
            s_d.slow_to[7:0] = reg_wdata;
        end
        if (reg_wr && ta_ok && reg_addr == ADDR_SLOW_TOH) begin
            s_d.slow_to[15:8] = reg_wdata;
        end
        if (wr_back_cfg) begin
            s_d.back_rf = s_q.back_rf & reg_wdata[BCFG_RF_BIT];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_STS) begin
            s_d.sts = s_q.sts & ~reg_wdata[STS_W-1:0];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_MSK) begin
            s_d.msk = reg_wdata[STS_W-1:0];
        end

        // Events after writes so that a set wins over a clear
        if (slow_if.match) begin
            s_d.sts[STS_SLOW] = 1'b1;
            if (s_q.slow_ren) begin
                s_d.slow_rf = 1'b1;
                s_d.rst_req = 1'b1;
            end else begin
                s_d.slow_if = 1'b1;
            end
        end
        if (back_if.match) begin
            s_d.back_rf       = 1'b1;
            s_d.sts[STS_BACK] = 1'b1;
            s_d.rst_req       = 1'b1;
        end
        if (main_expire) begin
            s_d.sts[STS_MAIN] = 1'b1;
            if (s_q.main_ren) begin
                s_d.rst_req = 1'b1;
            end
        end

        // Read data stands in the cycle after the read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SLOW_CFG: s_d.rdata = {1'b0, s_q.slow_ren, s_q.slow_rf, s_q.slow_ien, s_q.scale, s_q.slow_if};
                ADDR_SLOW_TOL: s_d.rdata = slow_if.count[7:0];
                ADDR_SLOW_TOH: s_d.rdata = slow_if.count[15:8];
                ADDR_BACK_CFG: s_d.rdata = {7'h00, s_q.back_rf};
                ADDR_BACK_TOL: s_d.rdata = back_if.count[7:0];
                ADDR_BACK_TOH: s_d.rdata = back_if.count[15:8];
                ADDR_TA:       s_d.rdata = {7'h00, ta_ok};
                ADDR_MAIN_CFG: s_d.rdata = {4'h0, s_q.main_ren, s_q.main_sel};
                ADDR_IRQ_STS:  s_d.rdata = {5'h00, s_q.sts};
                ADDR_IRQ_MSK:  s_d.rdata = {5'h00, s_q.msk};
                default:       s_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Flags survive the watchdog reset they request; reset sets slow_rf, slow_if and back_rf
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q          <= '0;
            s_q.main_sel <= MAIN_SEL_RST;
            s_q.main_ren <= MAIN_REN_RST;
            s_q.slow_ren <= SLOW_CFG_RST[CFG_REN_BIT];
            s_q.slow_rf  <= SLOW_CFG_RST[CFG_RF_BIT];
            s_q.slow_ien <= SLOW_CFG_RST[CFG_IEN_BIT];
            s_q.scale    <= SLOW_CFG_RST[CFG_CS_LSB +: 3];
            s_q.slow_if  <= SLOW_CFG_RST[CFG_IF_BIT];
            s_q.slow_to  <= SLOW_TO_RST;
            s_q.back_rf  <= BACK_CFG_RST[BCFG_RF_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata       = s_q.rdata;
    assign slow_dog_irq    = s_q.slow_if && s_q.slow_ien;
    assign slow_dog_wakeup = s_q.slow_if && s_q.slow_ien;
    assign wdog_reset_req  = s_q.rst_req;
    assign irq             = |(s_q.sts & s_q.msk);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_main_expiry_count: assert property (@(posedge ref_clk) disable iff (reset)
        main_expire |-> s_q.main_cnt == main_to(s_q.main_sel) - 1'b1)
        else $error("main watchdog expired at wrong count");

    a_main_halt_idle: assert property (@(posedge ref_clk) disable iff (reset)
        (cpu_idle || cpu_stop) && !(reg_wr && reg_addr == ADDR_MAIN_CFG) |=> $stable(s_q.main_cnt))
        else $error("main watchdog counted while halted");

    a_locked_timeout_kept: assert property (@(posedge ref_clk) disable iff (reset)
        reg_wr && !ta_ok && reg_addr == ADDR_SLOW_TOL |=> $stable(s_q.slow_to))
        else $error("locked write changed slow time-out");

    a_restart_needs_unlock: assert property (@(posedge ref_clk) disable iff (reset)
        reg_wr && reg_addr == ADDR_MAIN_CFG && reg_wdata[MCFG_RWT_BIT] && ta_ok |=> s_q.main_cnt == '0)
        else $error("unlocked restart did not clear main count");

    a_slow_clear_zero: assert property (@(posedge ref_clk) disable iff (reset)
        slow_if.clear |=> slow_if.count == 16'h0000)
        else $error("slow clear did not zero the count");

    a_slow_reset_flag: assert property (@(posedge ref_clk) disable iff (reset)
        slow_if.match && s_q.slow_ren |=> s_q.slow_rf && s_q.rst_req)
        else $error("slow match with reset enable missed reset");

    a_slow_irq_only: assert property (@(posedge ref_clk) disable iff (reset)
        slow_if.match && !s_q.slow_ren |=> s_q.slow_if && !$changed(s_q.slow_rf))
        else $error("slow match without reset enable misbehaved");

    a_backup_resets: assert property (@(posedge ref_clk) disable iff (reset)
        back_if.match |=> wdog_reset_req && s_q.back_rf)
        else $error("backup match gave no reset");

    a_irq_gated: assert property (@(posedge ref_clk) disable iff (reset)
        slow_dog_irq |-> s_q.slow_ien)
        else $error("slow irq raised while disabled");

    a_read_count: assert property (@(posedge ref_clk) disable iff (reset)
        reg_rd && reg_addr == ADDR_SLOW_TOL |=> reg_rdata == $past(slow_if.count[7:0]))
        else $error("slow time-out read did not return count");

    c_unlock_write: cover property (@(posedge ref_clk) disable iff (reset) wr_slow_cfg);
    c_slow_match:   cover property (@(posedge ref_clk) disable iff (reset) slow_if.match);
    c_back_match:   cover property (@(posedge ref_clk) disable iff (reset) back_if.match);
    c_main_expire:  cover property (@(posedge ref_clk) disable iff (reset) main_expire);

endmodule

// ---- dv/swd_tb.sv ----
// Self-checking bench of the slow-clock watchdog block, driven over its
// register port. Assumes the package, interface and design files under hw/
// are compiled first and that the main time-out counts are shortened.
`timescale 1ns/1ps
module testbench;
    import swd_pkg::*;

    // Shortened main expiry counts, one per select code
    localparam int LIM [4] = '{16, 32, 64, 128};

    logic        ref_clk;
    logic        reset;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        cpu_clk_en;
    logic        cpu_idle;
    logic        cpu_stop;
    logic        slow_dog_irq;
    logic        slow_dog_wakeup;
    logic        wdog_reset_req;
    logic        irq;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          cyc         = 0;
    int          last_cyc    = 0;
    int          gap         = 0;
    int          pulses      = 0;

    swd_top #(
        .MAIN_TO0 (27'(LIM[0])),
        .MAIN_TO1 (27'(LIM[1])),
        .MAIN_TO2 (27'(LIM[2])),
        .MAIN_TO3 (27'(LIM[3])),
        .SLOW_DIV (2)
    ) swd_top_i (
        .ref_clk         (ref_clk),
        .reset           (reset),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .cpu_clk_en      (cpu_clk_en),
        .cpu_idle        (cpu_idle),
        .cpu_stop        (cpu_stop),
        .slow_dog_irq    (slow_dog_irq),
        .slow_dog_wakeup (slow_dog_wakeup),
        .wdog_reset_req  (wdog_reset_req),
        .irq             (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset-pulse spacing monitor and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Gap between reset pulses; a hang ends the run well past the plan
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (wdog_reset_req === 1'b1) begin
            gap      <= cyc - last_cyc;
            last_cyc <= cyc;
            pulses   <= pulses + 1;
        end
        if (cyc > 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access and comparison tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Strobe left high so writes can follow back to back; idle drops it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge ref_clk);
    endtask

    task automatic unlock();
        wr(ADDR_TA, TA_KEY1);
        wr(ADDR_TA, TA_KEY2);
    endtask

    // Protected write: the unlock keys then the target, gapless
    task automatic tw(input logic [15:0] a, input logic [7:0] d);
        unlock();
        wr(a, d);
        idle(1);
    endtask

    task automatic wait_pulse();
        int p;
        int n;
        p = pulses;
        n = 0;
        while (pulses == p && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        check(n < 2000, 1'b1);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] ra [11];
        logic [7:0]  rv [11];
        int          p;
        ra = '{ADDR_SLOW_CFG, ADDR_SLOW_TOL, ADDR_SLOW_TOH, ADDR_BACK_CFG, ADDR_BACK_TOL,
               ADDR_BACK_TOH, ADDR_TA, ADDR_MAIN_CFG, ADDR_IRQ_STS, ADDR_IRQ_MSK, 16'hA0E4};
        rv = '{8'h27, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h00};
        reset      = 1'b1;
        reg_addr   = 16'h0000;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        cpu_clk_en = 1'b1;
        cpu_idle   = 1'b0;
        cpu_stop   = 1'b0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);

        // Reset values; time-out places read the live count
        for (int i = 0; i < 11; i++) begin
            rd(ra[i], rv[i]);
        end
        done("reset values");

        // Slow watchdog configuration under the lock
        wr(ADDR_SLOW_CFG, 8'h37);
        idle(1);
        rd(ADDR_SLOW_CFG, 8'h27);
        tw(ADDR_SLOW_CFG, 8'h37);
        rd(ADDR_SLOW_CFG, 8'h37);
        @(negedge ref_clk);
        check(slow_dog_irq, 1'b1);
        check(slow_dog_wakeup, 1'b1);
        @(posedge ref_clk);
        tw(ADDR_SLOW_CFG, 8'h36);
        rd(ADDR_SLOW_CFG, 8'h36);
        @(negedge ref_clk);
        check(slow_dog_irq, 1'b0);
        @(posedge ref_clk);
        tw(ADDR_SLOW_CFG, 8'h16);
        rd(ADDR_SLOW_CFG, 8'h16);
        tw(ADDR_SLOW_CFG, 8'h96);
        rd(ADDR_SLOW_CFG, 8'h16);
        tw(ADDR_SLOW_TOL, 8'h12);
        rd(ADDR_SLOW_TOL, 8'h00);
        // Window opens, then lapses after four cycles
        unlock();
        idle(1);
        rd(ADDR_TA, 8'h01);
        idle(6);
        rd(ADDR_TA, 8'h00);
        wr(ADDR_SLOW_CFG, 8'h00);
        idle(1);
        rd(ADDR_SLOW_CFG, 8'h16);
        done("slow config");

        // Backup watchdog clear and flag
        tw(ADDR_BACK_CFG, 8'h81);
        rd(ADDR_BACK_CFG, 8'h01);
        wr(ADDR_BACK_CFG, 8'h00);
        idle(1);
        rd(ADDR_BACK_CFG, 8'h01);
        tw(ADDR_BACK_CFG, 8'h00);
        rd(ADDR_BACK_CFG, 8'h00);
        tw(ADDR_BACK_TOL, 8'h55);
        rd(ADDR_BACK_TOL, 8'h00);
        done("backup config");

        // Select codes 0 to 3, restarted first so the count is below the limit
        for (int s = 0; s < 4; s++) begin
            unlock();
            wr(ADDR_MAIN_CFG, {5'h11, s[2:0]});
            idle(1);
            wait_pulse();
            wait_pulse();
            check(gap, LIM[s]);
        end
        done("main select");

        // Idle, stop and a held clock enable all freeze the count
        for (int m = 0; m < 3; m++) begin
            wait_pulse();
            p = pulses;
            cpu_idle   <= (m == 0);
            cpu_stop   <= (m == 1);
            cpu_clk_en <= (m != 2);
            repeat (300) @(posedge ref_clk);
            check(pulses, p);
            cpu_idle   <= 1'b0;
            cpu_stop   <= 1'b0;
            cpu_clk_en <= 1'b1;
        end
        done("main halt");

        // Restart is ignored while locked, honoured when unlocked
        wait_pulse();
        repeat (60) @(posedge ref_clk);
        wr(ADDR_MAIN_CFG, 8'h8B);
        idle(1);
        wait_pulse();
        check(gap, LIM[3]);
        repeat (60) @(posedge ref_clk);
        tw(ADDR_MAIN_CFG, 8'h8B);
        wait_pulse();
        check(gap > LIM[3], 1'b1);
        done("main restart");

        // Expiry status, mask and write-one clear
        wait_pulse();
        wr(ADDR_IRQ_MSK, 8'h01);
        idle(2);
        @(negedge ref_clk);
        check(irq, 1'b1);
        @(posedge ref_clk);
        wr(ADDR_IRQ_MSK, 8'h00);
        idle(2);
        @(negedge ref_clk);
        check(irq, 1'b0);
        @(posedge ref_clk);
        wr(ADDR_IRQ_MSK, 8'h01);
        wr(ADDR_IRQ_STS, 8'h01);
        idle(2);
        @(negedge ref_clk);
        check(irq, 1'b0);
        @(posedge ref_clk);
        rd(ADDR_IRQ_STS, 8'h00);
        done("interrupt");

        // Short slow time-out: irq only, then reset with its flag
        tw(ADDR_SLOW_TOL, 8'h02);
        tw(ADDR_SLOW_TOH, 8'h00);
        tw(ADDR_SLOW_CFG, 8'h96);
        repeat (1600) @(posedge ref_clk);
        rd(ADDR_SLOW_CFG, 8'h17);
        @(negedge ref_clk);
        check(slow_dog_irq, 1'b1);
        @(posedge ref_clk);
        tw(ADDR_SLOW_CFG, 8'hD6);
        repeat (1600) @(posedge ref_clk);
        rd(ADDR_SLOW_CFG, 8'h76);
        done("slow match");
        report_and_stop();
    end
endmodule
